// File: dct_chk.sv
`timescale 1ns/1ps
module dct_chk import dct_pkg::*; (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        cke,
  input wire dct_cmd_t    cmd,
  input wire logic [2:0]  ba,
  input wire logic [16:0] addr,
  input wire logic        beatValid,
  input wire logic [7:0]  beatData,
  input wire logic        beatCrc,
  input wire logic        gearSync,
  input wire logic        alertN,
  input wire logic        dllLocked
);
  logic [7:0] cntCke_r;
  logic [7:0] cntMrs_r;
  logic [7:0] cntSync_r;
  logic       gearMrs;

  assign gearMrs = cmd == CMD_MRS && ba == 3'h3 && addr[3];

  function automatic logic [7:0] inc8(input logic [7:0] x);
    return (x == 8'hFF) ? x : x + 8'h01;
  endfunction

  // cycles since cke high, gear-down mrs, last sync cycle
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cntCke_r  <= 8'h00;
      cntMrs_r  <= 8'hFF;
      cntSync_r <= 8'hFF;
    end
    else
    begin
      cntCke_r  <= cke ? inc8(cntCke_r) : 8'h00;
      cntMrs_r  <= gearMrs ? 8'h00 : inc8(cntMrs_r);
      cntSync_r <= gearSync ? 8'h00 : inc8(cntSync_r);
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  a_alert_fall: assert property (
    $fell(alertN) |-> $past(beatValid) && $past(beatCrc != ^beatData))
    else $error("alert fell without a bad beat");
  a_alert_low: assert property (
    $fell(alertN) |-> (!alertN)[*6])
    else $error("alert pulse too short");
  a_alert_end: assert property (
    $fell(alertN) ##0 (!beatValid)[*8] |-> ##[0:3] alertN)
    else $error("alert pulse too long");
  a_rd_locked: assert property (
    cmd inside {CMD_RD, CMD_RDA} |-> dllLocked)
    else $error("read issued without locked dll");
  a_mr7_gap: assert property (
    cmd == CMD_MRS && ba == 3'h7 |-> ##1 (cmd inside {CMD_DES, CMD_MRS})[*4])
    else $error("command too soon after mode register seven");
  a_gear_wait: assert property (
    gearMrs |-> cntCke_r >= 8'd20)
    else $error("gear-down mrs too soon after cke");
  // sync is sampled mid-pulse, two clocks after this count
  a_sync_delay: assert property (
    $rose(gearSync) |-> cntMrs_r >= 8'd25)
    else $error("sync pulse too soon after mrs");
  a_sync_hold: assert property (
    $rose(gearSync) |-> gearSync[*4] ##1 !gearSync)
    else $error("sync pulse not held four cycles");
  a_first_cmd: assert property (
    cmd != CMD_DES && cntSync_r != 8'hFF |-> cntSync_r >= 8'd23)
    else $error("command too soon after sync pulse");
  a_ref_gap: assert property (
    cmd == CMD_REF |-> ##1 (cmd == CMD_DES)[*3])
    else $error("command too soon after refresh");
endmodule

// File: dct_controller.sv
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "dct_map.svh"
module dct_controller import dct_pkg::*; (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  dct_if.ctl               link,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdata
);
  dct_ctl_st_t st_r;
  dct_ctl_st_t st_nxt;
  dct_cmd_t    wCmd;
  logic [2:0]  wBa;
  logic [16:0] wAddr;
  logic        isRead;
  logic        canIssue;
  logic        twoClkOk;
  logic        badCmd;
  logic [7:0]  rfcCyc;
  logic [7:0]  wrCyc;

  always_comb
  begin
    wCmd = dct_cmd_t'(regWdata[3:0]);
    wBa = regWdata[6:4];
    wAddr = regWdata[24:8];
    isRead = (st_r.pCmd == CMD_RD) || (st_r.pCmd == CMD_RDA);
    twoClkOk = (st_r.grade == `DCT_GRADE_2400) || (st_r.grade == `DCT_GRADE_2666)
      || (st_r.grade == `DCT_GRADE_3200);
    badCmd = st_r.pend || !st_r.initDone || (regWdata[3:0] > 4'(CMD_PDX));
    if ((wCmd == CMD_RD) || (wCmd == CMD_RDA))
      badCmd = badCmd || !link.dllLocked;
    if ((wCmd == CMD_MRS) && (wBa == `DCT_MR3) && wAddr[`DCT_PDA_BIT])
      badCmd = badCmd || !st_r.vrefOk;
    if ((wCmd == CMD_MRS) && (wBa == `DCT_MR4))
      badCmd = badCmd || ((wAddr[`DCT_RPRE_BIT] || wAddr[`DCT_WPRE_BIT]) && !twoClkOk);
    unique case (st_r.rfMode)
      2'h1: rfcCyc = 8'(`DCT_CYC_UP(`DCT_TRFC2_NS));
      2'h2: rfcCyc = 8'(`DCT_CYC_UP(`DCT_TRFC4_NS));
      default: rfcCyc = 8'(`DCT_CYC_UP(`DCT_REFRESH_CYCLE_TIME_NORMAL_NS));
    endcase
    wrCyc = st_r.crcDm ? 8'(`DCT_CYC_UP(`DCT_WRITE_RECOVERY_CRC_MASKED_NS))
      : 8'(`DCT_CYC_UP(`DCT_TWR_NS));
    canIssue = (st_r.rfcGap == 8'h00);
    if (st_r.pCmd != CMD_MRS)
      canIssue = canIssue && (st_r.mrGap == 8'h00);
    if (isRead)
      canIssue = canIssue && (st_r.wtrS == 8'h00)
        && ((st_r.pBa[`DCT_BG_BIT] != st_r.lastBg) || (st_r.wtrL == 8'h00));
    if (st_r.pCmd == CMD_PDE)
      canIssue = canIssue && (st_r.wpdGap == 8'h00);

    st_nxt = st_r;
    st_nxt.cmd = CMD_DES;
    st_nxt.beatValid = 1'b0;
    if (st_r.mrGap != 8'h00)
      st_nxt.mrGap = st_r.mrGap - 8'h01;
    if (st_r.rfcGap != 8'h00)
      st_nxt.rfcGap = st_r.rfcGap - 8'h01;
    if (st_r.wtrS != 8'h00)
      st_nxt.wtrS = st_r.wtrS - 8'h01;
    if (st_r.wtrL != 8'h00)
      st_nxt.wtrL = st_r.wtrL - 8'h01;
    if (st_r.wpdGap != 8'h00)
      st_nxt.wpdGap = st_r.wpdGap - 8'h01;
    if (st_r.initCnt != 16'h0000)
      st_nxt.initCnt = st_r.initCnt - 16'h0001;

    unique case (st_r.init)
      I_OFF:
      begin
        if (regWr && (regAddr == `DCT_REG_CTRL) && regWdata[0])
        begin
          st_nxt.cke = 1'b1;
          st_nxt.initCnt = (`DCT_TXPR > `DCT_TXS) ? `DCT_TXPR : `DCT_TXS;
          st_nxt.init = I_XPR;
        end
      end
      I_XPR:
      begin
        if (st_r.initCnt == 16'h0000)
        begin
          if (st_r.gearEn)
          begin
            st_nxt.cmd = CMD_MRS;
            st_nxt.ba = `DCT_MR3;
            st_nxt.addr = 17'h00000;
            st_nxt.addr[`DCT_GEAR_BIT] = 1'b1;
            st_nxt.initCnt = `DCT_EVEN(`DCT_TMOD + 16'h0004) - `DCT_GEAR_SETUP - 16'h0001;
            st_nxt.init = I_GSYNC;
          end
          else
          begin
            st_nxt.initDone = 1'b1;
            st_nxt.init = I_DONE;
          end
        end
      end
      I_GSYNC:
      begin
        if (st_r.initCnt == 16'h0000)
        begin
          st_nxt.gearSync = 1'b1;
          st_nxt.initCnt = `DCT_GEAR_SETUP + `DCT_GEAR_HOLD - 16'h0001;
          st_nxt.init = I_GHOLD;
        end
      end
      I_GHOLD:
      begin
        if (st_r.initCnt == 16'h0000)
        begin
          st_nxt.gearSync = 1'b0;
          st_nxt.initCnt = `DCT_EVEN(`DCT_TMOD) - `DCT_GEAR_HOLD;
          st_nxt.init = I_GCMD;
        end
      end
      I_GCMD:
      begin
        if (st_r.initCnt == 16'h0000)
        begin
          st_nxt.initDone = 1'b1;
          st_nxt.init = I_DONE;
        end
      end
      I_DONE:
      begin
        if (st_r.pend && canIssue)
        begin
          st_nxt.pend = 1'b0;
          st_nxt.cmd = st_r.pCmd;
          st_nxt.ba = st_r.pBa;
          st_nxt.addr = st_r.pAddr;
          if (st_r.pCmd == CMD_PDE)
            st_nxt.cke = 1'b0;
          if (st_r.pCmd == CMD_PDX)
            st_nxt.cke = 1'b1;
          if ((st_r.pCmd == CMD_MRS) && (st_r.pBa == `DCT_MR7))
            st_nxt.mrGap = `DCT_MR7_GAP;
          if ((st_r.pCmd == CMD_MRS) && (st_r.pBa == `DCT_MR2))
            st_nxt.wl = st_r.pAddr[`DCT_WL_LO +: 5];
          if (st_r.pCmd == CMD_REF)
            st_nxt.rfcGap = rfcCyc;
          if (st_r.pCmd == CMD_WR)
          begin
            st_nxt.wtrS = st_r.crcDm ? `DCT_WTR_S_CRC_DM : `DCT_WTR_S;
            st_nxt.wtrL = st_r.crcDm ? `DCT_WTR_L_CRC_DM : `DCT_WTR_L;
            st_nxt.lastBg = st_r.pBa[`DCT_BG_BIT];
            st_nxt.wpdGap = {3'h0, st_r.wl} + 8'h04 + wrCyc;
          end
        end
      end
      default: st_nxt.init = I_OFF;
    endcase

    if (regWr)
    begin
      unique case (regAddr)
        `DCT_REG_CTRL:
        begin
          st_nxt.gearEn = regWdata[1];
          st_nxt.vrefOk = regWdata[2];
          st_nxt.rfMode = regWdata[5:4];
          st_nxt.crcDm = regWdata[6];
          st_nxt.grade = regWdata[10:8];
        end
        `DCT_REG_CMD:
        begin
          if (badCmd)
            st_nxt.refused = 1'b1;
          else
          begin
            st_nxt.pend = 1'b1;
            st_nxt.pCmd = wCmd;
            st_nxt.pBa = wBa;
            st_nxt.pAddr = wAddr;
          end
        end
        `DCT_REG_WDATA:
        begin
          st_nxt.beatValid = 1'b1;
          st_nxt.beatData = regWdata[7:0];
          st_nxt.beatCrc = (^regWdata[7:0]) ^ regWdata[8];
        end
        `DCT_REG_STATUS:
        begin
          if (regWdata[3])
            st_nxt.alertSeen = 1'b0;
          if (regWdata[4])
            st_nxt.refused = 1'b0;
        end
        default: ;
      endcase
    end
    // set wins over clear
    if (!link.alertN)
      st_nxt.alertSeen = 1'b1;
    if (regWr && (regAddr == `DCT_REG_CMD) && badCmd)
      st_nxt.refused = 1'b1;

    st_nxt.rdata = 32'h0000_0000;
    if (regRd)
    begin
      unique case (regAddr)
        `DCT_REG_CTRL:
          st_nxt.rdata = {21'h000000, st_r.grade, 1'b0, st_r.crcDm, st_r.rfMode,
            1'b0, st_r.vrefOk, st_r.gearEn, 1'b0};
        `DCT_REG_CMD:
          st_nxt.rdata = {7'h00, st_r.pAddr, 1'b0, st_r.pBa, st_r.pCmd};
        `DCT_REG_STATUS:
          st_nxt.rdata = {26'h0000000, st_r.init == I_DONE, st_r.refused,
            st_r.alertSeen, link.dllLocked, st_r.initDone, st_r.pend};
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign link.cke       = st_r.cke;
  assign link.cmd       = st_r.cmd;
  assign link.ba        = st_r.ba;
  assign link.addr      = st_r.addr;
  assign link.beatValid = st_r.beatValid;
  assign link.beatData  = st_r.beatData;
  assign link.beatCrc   = st_r.beatCrc;
  assign link.gearSync  = st_r.gearSync;
  assign regRdata       = st_r.rdata;
endmodule

// File: dct_device.sv
`timescale 1ns/1ps
`include "dct_map.svh"
module dct_device import dct_pkg::*; (
  input  wire logic mclk,
  input  wire logic sys_rst,
  dct_if.dev        link,
  output logic      wrStart,
  output logic      powerDown,
  output logic      gearDownOn,
  output logic      wrPreambleTwo
);
  dct_dev_st_t st_r;
  dct_dev_st_t st_nxt;
  logic [5:0]  lead;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.wrStart = 1'b0;
    lead = st_r.rdPre2 ? 6'h02 : 6'h01;
    if (st_r.alertCnt != 4'h0)
      st_nxt.alertCnt = st_r.alertCnt - 4'h1;
    if (link.beatValid && st_r.crcEn && (link.beatCrc != ^link.beatData))
      st_nxt.alertCnt = `DCT_ALERT_PW;
    if (st_r.wrCnt != 6'h00)
    begin
      st_nxt.wrCnt = st_r.wrCnt - 6'h01;
      st_nxt.wrStart = (st_r.wrCnt == 6'h01);
    end
    if (st_r.rdCnt != 6'h00)
      st_nxt.rdCnt = st_r.rdCnt - 6'h01;
    if (st_r.busyCnt != 6'h00)
      st_nxt.busyCnt = st_r.busyCnt - 6'h01;
    if (st_r.dllEn && !st_r.dllLocked)
    begin
      st_nxt.dllCnt = st_r.dllCnt + 8'h01;
      st_nxt.dllLocked = (st_r.dllCnt == `DCT_DLLK_CYC);
    end
    if (st_r.gearEn && link.gearSync)
      st_nxt.gearOn = 1'b1;
    unique case (link.cmd)
      CMD_MRS:
      begin
        unique case (link.ba)
          `DCT_MR0:
          begin
            st_nxt.blMode = link.addr[`DCT_BL_LO +: 2];
            st_nxt.cl = link.addr[`DCT_CL_LO +: 5];
          end
          `DCT_MR1:
          begin
            st_nxt.dllEn = link.addr[`DCT_DLL_BIT];
            st_nxt.dllLocked = 1'b0;
            st_nxt.dllCnt = 8'h00;
          end
          `DCT_MR2:
          begin
            st_nxt.wl = link.addr[`DCT_WL_LO +: 5];
            st_nxt.crcEn = link.addr[`DCT_CRC_BIT];
          end
          `DCT_MR3: st_nxt.gearEn = link.addr[`DCT_GEAR_BIT];
          `DCT_MR4:
          begin
            st_nxt.rdPre2 = link.addr[`DCT_RPRE_BIT];
            st_nxt.wrPre2 = link.addr[`DCT_WPRE_BIT];
          end
          `DCT_MR5: st_nxt.dmEn = link.addr[`DCT_DM_BIT];
          default: ;
        endcase
      end
      CMD_ACT, CMD_PRE: st_nxt.busyCnt = `DCT_RP_CYC;
      CMD_REF: st_nxt.busyCnt = 6'(`DCT_CYC_UP(`DCT_REFRESH_CYCLE_TIME_NORMAL_NS));
      CMD_WR:
        st_nxt.wrCnt = {1'b0, st_r.wl}
          + ((st_r.blMode == `DCT_BL_FIX4) ? `DCT_WR_OFS_BC4 : `DCT_WR_OFS_BL8);
      CMD_RD, CMD_RDA: st_nxt.rdCnt = {1'b0, st_r.cl} + `DCT_BURST_CYC;
      CMD_DES, CMD_PDE, CMD_PDX: ;
      default: ;
    endcase
    st_nxt.dqsDrv = (st_nxt.rdCnt != 6'h00) && (st_nxt.rdCnt <= `DCT_BURST_CYC + lead);
    st_nxt.dqsOut = (st_nxt.rdCnt != 6'h00) && (st_nxt.rdCnt <= `DCT_BURST_CYC)
      ? ~st_r.dqsOut : 1'b0;
    st_nxt.pd = !link.cke && (st_r.busyCnt == 6'h00);
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign link.alertN    = (st_r.alertCnt == 4'h0);
  assign link.dllLocked = st_r.dllLocked;
  assign link.dqsOut    = st_r.dqsOut;
  assign link.dqsOeN    = !st_r.dqsDrv;
  assign wrStart        = st_r.wrStart;
  assign powerDown      = st_r.pd;
  assign gearDownOn     = st_r.gearOn;
  assign wrPreambleTwo  = st_r.wrPre2;
endmodule

// File: dct_if.sv
`timescale 1ns/1ps
interface dct_if;
  import dct_pkg::*;
  logic        cke;
  dct_cmd_t    cmd;
  logic [2:0]  ba;
  logic [16:0] addr;
  logic        beatValid;
  logic [7:0]  beatData;
  logic        beatCrc;
  logic        gearSync;
  logic        alertN;
  logic        dllLocked;
  logic        dqsOut;
  logic        dqsOeN;

  modport dev (
    input  cke, cmd, ba, addr, beatValid, beatData, beatCrc, gearSync,
    output alertN, dllLocked, dqsOut, dqsOeN
  );
  modport ctl (
    output cke, cmd, ba, addr, beatValid, beatData, beatCrc, gearSync,
    input  alertN, dllLocked, dqsOut, dqsOeN
  );
endinterface

// File: dct_map.svh
// Operation
// - alert falls 3 to 13 ns after crc error; here on the clock edge after the bad beat, 50 ns later
// - alert pulse lasts 6 to 10 clocks
// - gear-down mrs waits reset-exit time after cke
// - gear-down enable waits self-refresh exit time
// - sync pulse tmod plus four, even clocks
// - first command tmod after sync, even
// - burst eight internal write at wl plus 4
// - fixed chop four internal write at wl plus 2
// - reads and termination need locked dll
// - crc with mask uses masked write timings
// - nanoseconds to clocks rounded up
// - cke low accepted while operations finish
// - a11 selects read preamble toggle width
// - a12 selects two-clock preamble mode
// - two-clock toggle drives strobe one earlier
// - mode register seven needs five clocks
// - per-device addressing needs centred reference
// - any clock period if refresh kept
// - below 1600 use 1600 timings
`ifndef DCT_MAP_SVH
`define DCT_MAP_SVH

`define DCT_CLK_NS 50
`define DCT_CYC_UP(ns) ((((ns) + `DCT_CLK_NS - 1) / `DCT_CLK_NS) < 1 ? 1 : \
  (((ns) + `DCT_CLK_NS - 1) / `DCT_CLK_NS))
`define DCT_CYC_DN(ns) (((ns) / `DCT_CLK_NS) < 1 ? 1 : ((ns) / `DCT_CLK_NS))

`define DCT_ALERT_MIN_NS 3
`define DCT_ALERT_MAX_NS 13
`define DCT_ALERT_PW 4'h8
`define DCT_WR_OFS_BL8 6'h04
`define DCT_WR_OFS_BC4 6'h02
`define DCT_BURST_CYC 6'h04
`define DCT_DLLK_CYC 8'h3F
`define DCT_RP_CYC 6'h03
`define DCT_REFRESH_CYCLE_TIME_NORMAL_NS 350
`define DCT_TRFC2_NS 260
`define DCT_TRFC4_NS 160
`define DCT_TWR_NS 15
`define DCT_WRITE_RECOVERY_CRC_MASKED_NS 20
`define DCT_WTR_S 8'h02
`define DCT_WTR_S_CRC_DM 8'h04
`define DCT_WTR_L 8'h06
`define DCT_WTR_L_CRC_DM 8'h08
`define DCT_MR7_GAP 8'h05
`define DCT_TMOD 16'h0018
`define DCT_TXPR 16'h0014
`define DCT_TXS 16'h0014
`define DCT_GEAR_SETUP 16'h0002
`define DCT_GEAR_HOLD 16'h0002
`define DCT_EVEN(x) ((((x) + 16'h0001) >> 1) << 1)

`define DCT_BL_LO 0
`define DCT_CL_LO 4
`define DCT_WL_LO 0
`define DCT_DLL_BIT 0
`define DCT_GEAR_BIT 3
`define DCT_PDA_BIT 4
`define DCT_RPRE_BIT 11
`define DCT_WPRE_BIT 12
`define DCT_CRC_BIT 12
`define DCT_DM_BIT 10
`define DCT_BG_BIT 2
`define DCT_BL_FIX4 2'h2

`define DCT_MR0 3'h0
`define DCT_MR1 3'h1
`define DCT_MR2 3'h2
`define DCT_MR3 3'h3
`define DCT_MR4 3'h4
`define DCT_MR5 3'h5
`define DCT_MR7 3'h7

`define DCT_REG_CTRL 8'h00
`define DCT_REG_CMD 8'h04
`define DCT_REG_WDATA 8'h08
`define DCT_REG_STATUS 8'h0C
`define DCT_GRADE_2400 3'h3
`define DCT_GRADE_2666 3'h4
`define DCT_GRADE_3200 3'h6

`endif

// File: dct_pkg.sv
package dct_pkg;

  typedef enum logic [3:0] {
    CMD_DES, CMD_ACT, CMD_PRE, CMD_REF, CMD_WR,
    CMD_RD, CMD_RDA, CMD_MRS, CMD_PDE, CMD_PDX
  } dct_cmd_t;

  typedef enum logic [2:0] {
    I_OFF, I_XPR, I_GSYNC, I_GHOLD, I_GCMD, I_DONE
  } dct_init_t;

  typedef struct packed {
    logic [1:0] blMode;
    logic [4:0] wl;
    logic [4:0] cl;
    logic       dllEn;
    logic [7:0] dllCnt;
    logic       dllLocked;
    logic       gearEn;
    logic       gearOn;
    logic       rdPre2;
    logic       wrPre2;
    logic       crcEn;
    logic       dmEn;
    logic [3:0] alertCnt;
    logic [5:0] wrCnt;
    logic       wrStart;
    logic [5:0] rdCnt;
    logic       dqsOut;
    logic       dqsDrv;
    logic [5:0] busyCnt;
    logic       pd;
  } dct_dev_st_t;

  typedef struct packed {
    dct_init_t   init;
    logic [15:0] initCnt;
    logic        initDone;
    logic        gearEn;
    logic        vrefOk;
    logic [1:0]  rfMode;
    logic        crcDm;
    logic [2:0]  grade;
    logic        pend;
    dct_cmd_t    pCmd;
    logic [2:0]  pBa;
    logic [16:0] pAddr;
    logic        cke;
    dct_cmd_t    cmd;
    logic [2:0]  ba;
    logic [16:0] addr;
    logic        beatValid;
    logic [7:0]  beatData;
    logic        beatCrc;
    logic        gearSync;
    logic [7:0]  mrGap;
    logic [7:0]  rfcGap;
    logic [7:0]  wtrS;
    logic [7:0]  wtrL;
    logic [7:0]  wpdGap;
    logic        lastBg;
    logic [4:0]  wl;
    logic        alertSeen;
    logic        refused;
    logic [31:0] rdata;
  } dct_ctl_st_t;

endpackage

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  import dct_pkg::*;
  logic        mclk;
  logic        sys_rst;
  logic [7:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdata;
  logic        wrStart;
  logic        powerDown;
  logic        gearDownOn;
  logic        wrPreambleTwo;
  logic [31:0] rd;
  int          n_mismatch;
  int          n_compared;
  int          cyc;
  int          cmdCyc[16];
  int          wrCyc;
  int          alertLow;
  int          oeLow;
  int          dqsHigh;
  int          wl;
  int          expQ[$];

  dct_if link ();
  dct_device u_dct_device (.mclk(mclk), .sys_rst(sys_rst), .link(link.dev),
    .wrStart(wrStart), .powerDown(powerDown), .gearDownOn(gearDownOn),
    .wrPreambleTwo(wrPreambleTwo));
  dct_controller u_dct_controller (.mclk(mclk), .sys_rst(sys_rst), .link(link.ctl),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata));
  dct_chk u_dct_chk (.mclk(mclk), .sys_rst(sys_rst), .cke(link.cke), .cmd(link.cmd),
    .ba(link.ba), .addr(link.addr), .beatValid(link.beatValid),
    .beatData(link.beatData), .beatCrc(link.beatCrc), .gearSync(link.gearSync),
    .alertN(link.alertN), .dllLocked(link.dllLocked));

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // link monitor: command cycles, pulse widths
  always @(negedge mclk)
  begin
    cyc++;
    if (link.cmd !== CMD_DES)
      cmdCyc[int'(link.cmd)] = cyc;
    if (wrStart === 1'b1)
      wrCyc = cyc;
    if (link.alertN === 1'b0)
      alertLow++;
    if (link.dqsOeN === 1'b0)
      oeLow++;
    if (link.dqsOut === 1'b1)
      dqsHigh++;
  end

  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  task automatic rdReg(input logic [7:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    rd = regRdata;
  endtask

  function automatic logic [31:0] cw(input dct_cmd_t c, input logic [2:0] b,
                                     input logic [16:0] a);
    return {7'h00, a, 1'b0, b, c};
  endfunction

  // issue a command, then poll status until nothing is pending
  task automatic cmdReg(input dct_cmd_t c, input logic [2:0] b, input logic [16:0] a);
    wr(8'h04, cw(c, b, a));
    for (int i = 0; i < 100; i++)
    begin
      rdReg(8'h0C);
      if (rd[0] === 1'b0)
        break;
    end
  endtask

  task automatic waitBit(input int b);
    for (int i = 0; i < 400; i++)
    begin
      rdReg(8'h0C);
      if (rd[b] === 1'b1)
        break;
    end
  endtask

  task automatic refused(input dct_cmd_t c, input logic [2:0] b, input logic [16:0] a);
    cmdReg(c, b, a);
    rdReg(8'h0C);
    check(rd[4], 1'b1);
    wr(8'h0C, 32'h0000_0010);
  endtask

  initial
  begin
    #(50 * 30000);
    n_mismatch++;
    finish_test();
  end

  initial
  begin
    sys_rst  = 1'b1;
    regAddr  = 8'h00;
    regWdata = 32'h0000_0000;
    regWr    = 1'b0;
    regRd    = 1'b0;
    void'($urandom(67631));
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    rdReg(8'h0C);
    check(rd & 32'h0000_001F, 32'h0000_0000);
    rdReg(8'h10);
    check(rd, 32'h0000_0000);
    refused(CMD_RD, 3'h0, 17'h00000);
    wr(8'h00, 32'h0000_0307);
    rdReg(8'h00);
    check(rd, 32'h0000_0306);
    waitBit(1);
    check(gearDownOn, 1'b1);
    refused(CMD_RD, 3'h0, 17'h00000);
    cmdReg(CMD_MRS, 3'h1, 17'h00001);
    waitBit(2);
    check(rd[2], 1'b1);
    wr(8'h04, cw(CMD_MRS, 3'h7, 17'h00000));
    wr(8'h04, cw(CMD_RD, 3'h0, 17'h00000));
    repeat (30) @(posedge mclk);
    check(cmdCyc[5] - cmdCyc[7] >= 5, 1'b1);
    for (int bl = 0; bl < 3; bl++)
    begin
      wl = 9 + $urandom % 12;
      cmdReg(CMD_MRS, 3'h0, 17'h000A0 | 17'(bl));
      cmdReg(CMD_MRS, 3'h2, 17'(wl));
      cmdReg(CMD_WR, 3'h0, 17'h00000);
      expQ.push_back(wl + ((bl == 2) ? 2 : 4) + 1);
      repeat (30) @(posedge mclk);
      check(wrCyc - cmdCyc[4], expQ.pop_front());
    end
    cmdReg(CMD_MRS, 3'h5, 17'h00400);
    for (int k = 0; k < 2; k++)
    begin
      wr(8'h00, k ? 32'h0000_0346 : 32'h0000_0306);
      wr(8'h04, cw(CMD_WR, 3'h0, 17'h00000));
      wr(8'h04, cw(CMD_RD, 3'h0, 17'h00000));
      repeat (40) @(posedge mclk);
      expQ.push_back(cmdCyc[5] - cmdCyc[4]);
    end
    check(expQ[1] - expQ[0], 2);
    cmdReg(CMD_MRS, 3'h2, 17'h01000 | 17'(wl));
    for (int k = 0; k < 2; k++)
    begin
      alertLow = 0;
      wr(8'h08, {23'h0, k == 0, 8'($urandom)});
      repeat (20) @(posedge mclk);
      check(alertLow, (k == 0) ? 8 : 0);
    end
    rdReg(8'h0C);
    check(rd[3], 1'b1);
    wr(8'h0C, 32'h0000_0008);
    rdReg(8'h0C);
    check(rd[3], 1'b0);
    for (int p = 0; p < 2; p++)
    begin
      cmdReg(CMD_MRS, 3'h4, 17'(p) << 11);
      oeLow = 0;
      dqsHigh = 0;
      cmdReg(CMD_RD, 3'h0, 17'h00000);
      repeat (30) @(posedge mclk);
      check(oeLow, 5 + p);
      check(dqsHigh, 2);
    end
    cmdReg(CMD_MRS, 3'h4, 17'h01000);
    check(wrPreambleTwo, 1'b1);
    wr(8'h00, 32'h0000_0002);
    refused(CMD_MRS, 3'h4, 17'h00800);
    refused(CMD_MRS, 3'h3, 17'h00010);
    for (int m = 0; m < 3; m++)
    begin
      wr(8'h00, 32'h0000_0002 | (m << 4));
      cmdReg(CMD_REF, 3'h0, 17'h00000);
      cmdReg(CMD_ACT, 3'h0, 17'h00000);
      check(cmdCyc[1] - cmdCyc[3] >= ((m == 0) ? 7 : (m == 1) ? 6 : 4), 1'b1);
    end
    cmdReg(CMD_PDE, 3'h0, 17'h00000);
    repeat (12) @(posedge mclk);
    check(powerDown, 1'b1);
    finish_test();
  end
endmodule
